// ---- rtl/luime_pkg.sv ----
// Constants, field positions and carrier types for the line unit interrupt mask and edge logic.
// Assumes one register clock shared by the control port, the detectors and this block.
package luime_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NUM_CH  = 2;
  localparam int LIVE_W  = 5;
  localparam int PULSE_W = 8;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register offsets within a channel page; address bits 7:5 carry the channel page
  localparam logic [4:0] OFS_MASK0  = 5'h13;
  localparam logic [4:0] OFS_MASK1  = 5'h14;
  localparam logic [4:0] OFS_EDGE   = 5'h15;
  localparam logic [4:0] OFS_LIVE   = 5'h16;
  localparam logic [4:0] OFS_ISTAT0 = 5'h18;
  localparam logic [4:0] OFS_ISTAT1 = 5'h19;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [4:0] MASK0_RST  = 5'h1f;
  localparam logic [2:0] MASK0_RSVD = 3'h7;
  localparam logic [7:0] MASK1_RST  = 8'hff;
  localparam logic [4:0] EDGE_RST   = 5'h00;
  localparam logic [2:0] EDGE_RSVD  = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Field positions of the status-based sources (mask 0, edge select, live status)
  localparam int SYNC_BIT  = 4;
  localparam int TXCLK_BIT = 3;
  localparam int DRV_BIT   = 2;
  localparam int AIS_BIT   = 1;
  localparam int LOS_BIT   = 0;

  // Field positions of the pulse sources (mask 1)
  localparam int WAVE_BIT  = 7;
  localparam int JOV_BIT   = 6;
  localparam int JUD_BIT   = 5;
  localparam int SEQ_BIT   = 4;
  localparam int EXZ_BIT   = 3;
  localparam int CV_BIT    = 2;
  localparam int TICK_BIT  = 1;
  localparam int CNTOV_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } luime_cpu_t;

  typedef struct packed {
    logic [LIVE_W-1:0]  live;
    logic [PULSE_W-1:0] pulse;
  } luime_src_t;

endpackage

// ---- rtl/luime_edge_det.sv ----
// Transition detector for the five real-time line status bits of one channel.
// Assumes the status bits come from logic on sys_clk, so no synchroniser is needed.
`timescale 1ns/1ps
`default_nettype none
module luime_edge_det (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // Status and selection
  input  wire logic [luime_pkg::LIVE_W-1:0] live,
  input  wire logic [luime_pkg::LIVE_W-1:0] edge_sel,
  // Event pulses
  output logic      [luime_pkg::LIVE_W-1:0] event_pls
);

  logic [luime_pkg::LIVE_W-1:0] prev_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= live;
    end
  end

  // Rising edge always counts; a falling edge counts only where both edges are selected
  assign event_pls = (live & ~prev_r) | (edge_sel & prev_r & ~live);

endmodule
`default_nettype wire

// ---- rtl/luime_flag_bank.sv ----
// Sticky event flags with per-bit mask, clear on read, and the combined request.
// Assumes the clear strobe is a one-cycle read pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module luime_flag_bank #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Events and control
  input  wire logic [W-1:0] set_pls,
  input  wire logic [W-1:0] mask,
  input  wire logic         clr,
  // State
  output logic      [W-1:0] flags_r,
  output logic              req
);

  logic [W-1:0] flags_nxt;

  // A set in the clearing cycle wins, so no event is lost to a read
  assign flags_nxt = (set_pls & ~mask) | (flags_r & ~{W{clr}});

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Masking a pending flag later also withdraws its request
  assign req = |(flags_r & ~mask);

endmodule
`default_nettype wire

// ---- rtl/luime_top.sv ----
// Interrupt mask and trigger-edge logic for both line channels, with the control port decode.
// Assumes a one-cycle write or read strobe on sys_clk and status/pulse sources on the same clock.
//
// Behaviour
// - Each channel has its own first mask register, at 0x13 and 0x33.
// - First mask bit 4 gates the sync event; 0 enables, resets 1.
// - First mask bit 3 gates transmit clock loss; 0 enables, resets 1.
// - First mask bit 2 gates line driver failure; 0 enables, resets 1.
// - First mask bits 1 and 0 gate alarm signal and signal loss; reset 1.
// - First mask bits 7 to 5 are reserved and read 111.
// - Second mask bit 7 gates waveform amplitude overflow; 0 enables, resets 1.
// - Second mask bit 6 gates jitter buffer overflow; 0 enables, resets 1.
// - Second mask bit 5 gates jitter buffer underflow; 0 enables, resets 1.
// - Second mask bit 4 gates sequence logic error; 0 enables, resets 1.
// - Second mask bit 3 gates received excess zeros; 0 enables, resets 1.
// - Second mask bit 2 gates received code violation; 0 enables, resets 1.
// - Second mask bit 1 gates one-second tick; 0 enables, resets 1.
// - Second mask bit 0 gates counter overflow; 0 enables, resets 1.
// - Edge bit 4: sync status events on rise only (0) or any change (1).
// - Edge bit 3 selects rise-only or both edges for transmit clock loss.
// - Edge bit 2 selects rise-only or both edges for driver failure.
// - Edge bit 1 selects rise-only or both edges for alarm signal.
// - Edge bit 0 selects edges for signal loss; bits 7 to 5 read zero.
// - Status events interrupt only while unmasked, on the selected transition.
// - Reading an interrupt status register clears its flags and request.
`timescale 1ns/1ps
`default_nettype none
module luime_top (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 arst_n,
  // Control port
  input  wire luime_pkg::luime_cpu_t                cpu,
  output logic      [7:0]                           cpu_rdata_r,
  // Event sources per channel
  input  wire luime_pkg::luime_src_t [luime_pkg::NUM_CH-1:0] src,
  // Interrupt requests per channel
  output logic      [luime_pkg::NUM_CH-1:0]         irq_r
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic is_reg(input logic [7:0] a, input logic [2:0] page, input logic [4:0] ofs);
    is_reg = (a[7:5] == page) && (a[4:0] == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Per-channel registers and state

  logic [4:0]                    mask0_r [luime_pkg::NUM_CH];
  logic [7:0]                    mask1_r [luime_pkg::NUM_CH];
  logic [4:0]                    edge_r  [luime_pkg::NUM_CH];
  logic [luime_pkg::LIVE_W-1:0]  istat0  [luime_pkg::NUM_CH];
  logic [luime_pkg::PULSE_W-1:0] istat1  [luime_pkg::NUM_CH];
  logic [luime_pkg::NUM_CH-1:0]  req0;
  logic [luime_pkg::NUM_CH-1:0]  req1;
  logic [7:0]                    rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are not stored

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < luime_pkg::NUM_CH; c++) begin
        mask0_r[c] <= luime_pkg::MASK0_RST;
        mask1_r[c] <= luime_pkg::MASK1_RST;
        edge_r[c]  <= luime_pkg::EDGE_RST;
      end
    end else begin
      for (int c = 0; c < luime_pkg::NUM_CH; c++) begin
        if (cpu.wr && is_reg(cpu.addr, 3'(c), luime_pkg::OFS_MASK0)) begin
          mask0_r[c] <= cpu.wdata[4:0];
        end
        if (cpu.wr && is_reg(cpu.addr, 3'(c), luime_pkg::OFS_MASK1)) begin
          mask1_r[c] <= cpu.wdata;
        end
        if (cpu.wr && is_reg(cpu.addr, 3'(c), luime_pkg::OFS_EDGE)) begin
          edge_r[c] <= cpu.wdata[4:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Event qualification per channel

  for (genvar ch = 0; ch < luime_pkg::NUM_CH; ch++) begin : g_ch
    logic                         sync_event_mask;
    logic                         tx_clock_loss_mask;
    logic                         driver_fault_mask;
    logic                         alarm_signal_mask;
    logic                         signal_loss_mask;
    logic                         wave_amp_overflow_mask;
    logic                         jitter_overflow_mask;
    logic                         jitter_underflow_mask;
    logic                         sequence_error_mask;
    logic                         excess_zeros_mask;
    logic                         code_violation_mask;
    logic                         second_tick_mask;
    logic                         counter_overflow_mask;
    logic [luime_pkg::LIVE_W-1:0]  live_mask;
    logic [luime_pkg::PULSE_W-1:0] pulse_mask;
    logic [luime_pkg::LIVE_W-1:0]  live_evt;

    assign sync_event_mask        = mask0_r[ch][luime_pkg::SYNC_BIT];
    assign tx_clock_loss_mask     = mask0_r[ch][luime_pkg::TXCLK_BIT];
    assign driver_fault_mask      = mask0_r[ch][luime_pkg::DRV_BIT];
    assign alarm_signal_mask      = mask0_r[ch][luime_pkg::AIS_BIT];
    assign signal_loss_mask       = mask0_r[ch][luime_pkg::LOS_BIT];
    assign wave_amp_overflow_mask = mask1_r[ch][luime_pkg::WAVE_BIT];
    assign jitter_overflow_mask   = mask1_r[ch][luime_pkg::JOV_BIT];
    assign jitter_underflow_mask  = mask1_r[ch][luime_pkg::JUD_BIT];
    assign sequence_error_mask    = mask1_r[ch][luime_pkg::SEQ_BIT];
    assign excess_zeros_mask      = mask1_r[ch][luime_pkg::EXZ_BIT];
    assign code_violation_mask    = mask1_r[ch][luime_pkg::CV_BIT];
    assign second_tick_mask       = mask1_r[ch][luime_pkg::TICK_BIT];
    assign counter_overflow_mask  = mask1_r[ch][luime_pkg::CNTOV_BIT];

    assign live_mask  = {sync_event_mask, tx_clock_loss_mask, driver_fault_mask,
                         alarm_signal_mask, signal_loss_mask};
    assign pulse_mask = {wave_amp_overflow_mask, jitter_overflow_mask, jitter_underflow_mask,
                         sequence_error_mask, excess_zeros_mask, code_violation_mask,
                         second_tick_mask, counter_overflow_mask};

    luime_edge_det u_edge (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .live      (src[ch].live),
      .edge_sel  (edge_r[ch]),
      .event_pls (live_evt)
    );

    // Status sources gated by mask 0, cleared by reading interrupt status 0
    luime_flag_bank #(.W(luime_pkg::LIVE_W)) u_flags0 (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .set_pls (live_evt),
      .mask    (live_mask),
      .clr     (cpu.rd && is_reg(cpu.addr, 3'(ch), luime_pkg::OFS_ISTAT0)),
      .flags_r (istat0[ch]),
      .req     (req0[ch])
    );

    // Pulse sources gated by mask 1, cleared by reading interrupt status 1
    luime_flag_bank #(.W(luime_pkg::PULSE_W)) u_flags1 (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .set_pls (src[ch].pulse),
      .mask    (pulse_mask),
      .clr     (cpu.rd && is_reg(cpu.addr, 3'(ch), luime_pkg::OFS_ISTAT1)),
      .flags_r (istat1[ch]),
      .req     (req1[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero

  always_comb begin
    rdata_nxt = 8'h00;
    for (int c = 0; c < luime_pkg::NUM_CH; c++) begin
      if (is_reg(cpu.addr, 3'(c), luime_pkg::OFS_MASK0)) begin
        rdata_nxt = {luime_pkg::MASK0_RSVD, mask0_r[c]};
      end
      if (is_reg(cpu.addr, 3'(c), luime_pkg::OFS_MASK1)) begin
        rdata_nxt = mask1_r[c];
      end
      if (is_reg(cpu.addr, 3'(c), luime_pkg::OFS_EDGE)) begin
        rdata_nxt = {luime_pkg::EDGE_RSVD, edge_r[c]};
      end
      if (is_reg(cpu.addr, 3'(c), luime_pkg::OFS_LIVE)) begin
        rdata_nxt = {3'h0, src[c].live};
      end
      if (is_reg(cpu.addr, 3'(c), luime_pkg::OFS_ISTAT0)) begin
        rdata_nxt = {3'h0, istat0[c]};
      end
      if (is_reg(cpu.addr, 3'(c), luime_pkg::OFS_ISTAT1)) begin
        rdata_nxt = istat1[c];
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_rdata_r <= 8'h00;
    end else if (cpu.rd) begin
      cpu_rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Interrupt request; registered, so it lags the flags by one cycle

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= '0;
    end else begin
      irq_r <= req0 | req1;
    end
  end

endmodule
`default_nettype wire

// ---- bench/luime_checker_assertions.sv ----
// Checker for the line unit interrupt mask and edge logic; channel 0 is tracked in shadow registers.
// Assumes it is bound to luime_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module luime_checker (
  // Clock and reset
  input wire logic                                          sys_clk,
  input wire logic                                          arst_n,
  // Control port
  input wire luime_pkg::luime_cpu_t                         cpu,
  input wire logic [7:0]                                    cpu_rdata_r,
  // Sources and requests
  input wire luime_pkg::luime_src_t [luime_pkg::NUM_CH-1:0] src,
  input wire logic [luime_pkg::NUM_CH-1:0]                  irq_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadows reset like the design so the first edges after release agree
  logic [4:0] m0_r;
  logic [7:0] m1_r;
  logic [4:0] es_r;
  logic [4:0] lq_r;
  logic       cause;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      m0_r <= 5'h1f;
      m1_r <= 8'hff;
      es_r <= 5'h00;
      lq_r <= 5'h00;
    end else begin
      lq_r <= src[0].live;
      if (cpu.wr && cpu.addr == 8'h13) m0_r <= cpu.wdata[4:0];
      if (cpu.wr && cpu.addr == 8'h14) m1_r <= cpu.wdata;
      if (cpu.wr && cpu.addr == 8'h15) es_r <= cpu.wdata[4:0];
    end
  end
  assign cause = (src[0].pulse != 8'h00) || (src[0].live != lq_r) || cpu.wr;
  ////////////////////////////////////////////////////////////////////////////////
  property p_mask0_rsvd; cpu.rd && cpu.addr[4:0] == 5'h13 && cpu.addr[7:5] < 3'h2 |=> cpu_rdata_r[7:5] == 3'h7; endproperty
  a_mask0_rsvd: assert property (p_mask0_rsvd) else $error("mask 0 reserved bits not 111");
  property p_edge_rsvd; cpu.rd && cpu.addr[4:0] == 5'h15 |=> cpu_rdata_r[7:5] == 3'h0; endproperty
  a_edge_rsvd: assert property (p_edge_rsvd) else $error("edge select reserved bits not zero");
  property p_unmapped; cpu.rd && cpu.addr[7:5] > 3'h1 |=> cpu_rdata_r == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("page outside both channels read nonzero");
  property p_pulse_irq; (src[0].pulse & ~m1_r) != 8'h00 && !cpu.wr |-> ##2 irq_r[0]; endproperty
  a_pulse_irq: assert property (p_pulse_irq) else $error("unmasked pulse raised no request");
  property p_all_masked; m0_r == 5'h1f && m1_r == 8'hff |=> !irq_r[0]; endproperty
  a_all_masked: assert property (p_all_masked) else $error("request while every source masked");
  property p_rise; (src[0].live & ~lq_r & ~m0_r) != 5'h00 && !cpu.wr |-> ##2 irq_r[0]; endproperty
  a_rise: assert property (p_rise) else $error("unmasked rising status raised no request");
  property p_both; (~src[0].live & lq_r & es_r & ~m0_r) != 5'h00 && !cpu.wr |-> ##2 irq_r[0]; endproperty
  a_both: assert property (p_both) else $error("falling status with both edges raised no request");
  property p_rose_cause; $rose(irq_r[0]) |-> $past(cause, 2); endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("request rose without an event or write");
  property p_clear; (cpu.rd && cpu.addr == 8'h18 && src[0].live == lq_r) ##1 (cpu.rd && cpu.addr == 8'h18) |=> cpu_rdata_r == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("status flags survived a read");
endmodule

bind luime_top luime_checker u_chk (
  .sys_clk     (sys_clk),
  .arst_n      (arst_n),
  .cpu         (cpu),
  .cpu_rdata_r (cpu_rdata_r),
  .src         (src),
  .irq_r       (irq_r)
);
`default_nettype wire

// ---- bench/luime_top_tb.sv ----
// Self-checking bench for luime_top: register map, pulse sources and status edges on both channels.
// Assumes the checker file is compiled alongside; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module luime_top_tb;
  logic                                          sys_clk;
  logic                                          arst_n;
  luime_pkg::luime_cpu_t                         cpu;
  logic [7:0]                                    cpu_rdata_r;
  luime_pkg::luime_src_t [luime_pkg::NUM_CH-1:0] src;
  logic [luime_pkg::NUM_CH-1:0]                  irq_r;
  int                                            fail_count;
  int                                            comparisons;

  luime_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .cpu(cpu), .cpu_rdata_r(cpu_rdata_r), .src(src), .irq_r(irq_r));

  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpu.addr = a;
    cpu.wdata = d;
    cpu.wr = 1'h1;
    @(negedge sys_clk);
    cpu.wr = 1'h0;
  endtask
  // Holding the strobe n cycles gives back-to-back reads; the last one is judged
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input int n);
    @(negedge sys_clk);
    cpu.addr = a;
    cpu.rd = 1'h1;
    repeat (n) @(negedge sys_clk);
    cpu.rd = 1'h0;
    chk(cpu_rdata_r, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int c = 0; c < 2; c++) begin
      rd(8'(c) << 5 | 8'h13, 8'hff, 1);
      rd(8'(c) << 5 | 8'h14, 8'hff, 1);
      rd(8'(c) << 5 | 8'h15, 8'h00, 1);
    end
  endtask
  task automatic t_regs;
    wr(8'h13, 8'h00);
    wr(8'h33, 8'h15);
    wr(8'h15, 8'hff);
    wr(8'h14, 8'h5a);
    rd(8'h13, 8'he0, 1);
    rd(8'h33, 8'hf5, 1);
    rd(8'h15, 8'h1f, 1);
    rd(8'h14, 8'h5a, 1);
    rd(8'h1a, 8'h00, 1);
    rd(8'h53, 8'h00, 1);
    wr(8'h13, 8'hff);
    wr(8'h33, 8'hff);
    wr(8'h15, 8'h00);
    wr(8'h14, 8'hff);
  endtask
  // All eight pulses fire each time; only the one unmasked source may latch
  task automatic t_pulse;
    for (int c = 0; c < 2; c++) begin
      for (int i = -1; i < 8; i++) begin
        if (i >= 0) wr(8'(c) << 5 | 8'h14, ~(8'h01 << i));
        @(negedge sys_clk);
        src[c].pulse = 8'hff;
        @(negedge sys_clk);
        src[c].pulse = 8'h00;
        @(negedge sys_clk);
        chk(8'(irq_r), (i >= 0) ? 8'(2'h1 << c) : 8'h00);
        rd(8'(c) << 5 | 8'h19, (i >= 0) ? 8'h01 << i : 8'h00, 1);
        repeat (2) @(negedge sys_clk);
        chk(8'(irq_r), 8'h00);
      end
      wr(8'(c) << 5 | 8'h14, 8'hff);
    end
  endtask
  // Every status bit rises and falls together; masked ones must stay silent
  task automatic t_live;
    for (int c = 0; c < 2; c++) begin
      for (int j = 0; j < 5; j++) begin
        for (int e = 0; e < 2; e++) begin
          wr(8'(c) << 5 | 8'h13, 8'hff ^ (8'h01 << j));
          wr(8'(c) << 5 | 8'h15, 8'(e) << j);
          src[c].live = 5'h1f;
          repeat (2) @(negedge sys_clk);
          chk(8'(irq_r), 8'(2'h1 << c));
          rd(8'(c) << 5 | 8'h16, 8'h1f, 1);
          rd(8'(c) << 5 | 8'h18, 8'h01 << j, 1);
          src[c].live = 5'h00;
          repeat (2) @(negedge sys_clk);
          rd(8'(c) << 5 | 8'h18, 8'(e) << j, 1);
          rd(8'(c) << 5 | 8'h18, 8'h00, 2);
        end
      end
      wr(8'(c) << 5 | 8'h13, 8'hff);
      wr(8'(c) << 5 | 8'h15, 8'h00);
    end
  endtask
  // A pulse in the very cycle of the clearing read must survive it
  task automatic t_race;
    wr(8'h14, 8'hfe);
    @(negedge sys_clk);
    cpu.addr = 8'h19;
    cpu.rd = 1'h1;
    src[0].pulse = 8'h01;
    @(negedge sys_clk);
    cpu.rd = 1'h0;
    src[0].pulse = 8'h00;
    chk(cpu_rdata_r, 8'h00);
    rd(8'h19, 8'h01, 1);
    wr(8'h14, 8'hff);
  endtask
  // Reset in mid-run with a request pending must restore every default
  task automatic t_midreset;
    wr(8'h14, 8'h00);
    wr(8'h13, 8'h00);
    wr(8'h15, 8'h1f);
    src[0].pulse = 8'h01;
    @(negedge sys_clk);
    src[0].pulse = 8'h00;
    @(negedge sys_clk);
    chk(8'(irq_r), 8'h01);
    arst_n = 1'h0;
    @(negedge sys_clk);
    chk(8'(irq_r), 8'h00);
    arst_n = 1'h1;
    t_reset();
    rd(8'h19, 8'h00, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    arst_n = 1'h0;
    cpu = '0;
    src = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (16) @(negedge sys_clk);
    arst_n = 1'h1;
    t_reset();
    t_regs();
    t_pulse();
    t_live();
    t_race();
    t_midreset();
    close_out();
  end
  // Whole run needs about 600 cycles; this allows 10000, over fifteen times that
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
